// >>> swfwd_regs.svh
// Register offsets, reset values and table geometry of the forwarding control block
`ifndef SWFWD_REGS_SVH
`define SWFWD_REGS_SVH
`define OFF_CTRL 8'h00
`define OFF_MIR_TX 8'h04
`define OFF_MIR_RX 8'h08
`define OFF_MONITOR 8'h0c
`define OFF_TRUNK0 8'h10
`define OFF_VLAN_MEMBER 8'h20
`define OFF_STP_FWD 8'h24
`define OFF_MIR_DROPS 8'h28
`define OFF_LINK_UP 8'h2c
`define OFF_UC_BASE 8'h40
`define UC_STRIDE 8'h08
`define OFF_MC_BASE 8'h80
`define MC_STRIDE 8'h10
`define RST_CTRL 32'h0000_0000
`define RST_MASK 32'h0000_0000
`define RST_ALL_ON 32'hffff_ffff
`define CTRL_MIR_EN 0
`define ENT_VALID 31
`define UC_PORT_LSB 16
`define MC_VID_LSB 16
`define MAC_MCAST_BIT 40
`endif

// >>> swfwd_pkg.sv
// Types shared by the forwarding control block
package swfwd_pkg;
  typedef logic [47:0] mac_t;
  typedef logic [11:0] vid_t;
  typedef logic [31:0] word_t;
  typedef enum {FWD_UNICAST, FWD_MCAST_STATIC, FWD_FLOOD, FWD_DROP} fwd_kind_e;
endpackage

// >>> switch_fwd_ctrl.sv
// Mirroring, trunk aggregation and static address filtering for a switch
//
// Overview of operation
// - Global mirror enable gates every copy.
// - Copy selected Tx/Rx port frames to monitor.
// - Drop copies when monitor is full.
// - Trunk holds exactly two, four or eight ports.
// - Wide variant: fixed n/n+12 groupings, gigabit pair.
// - Narrow variant: pairs 1-2..7-8, quads 1-4, 5-8.
// - A port belongs to one trunk only.
// - Trunk members never mirror source or monitor.
// - Traffic to a trunk spread over members.
// - Failed member's traffic moves to others.
// - Spanning tree state shared by trunk members.
// - VLAN membership changes for whole trunk.
// - Static unicast addresses never age, not learned.
// - Static source on wrong port is dropped.
// - Static multicast by VLAN+MAC restricts ports.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "swfwd_regs.svh"
module switch_fwd_ctrl import swfwd_pkg::*; #(
  parameter int NPORTS = 26,     // Switch ports, at most 32
  parameter bit WIDE = 1'b1,     // 1: 24+2 port groupings, 0: eight-port groupings
  parameter int NTRUNK = 4,      // Trunk slots
  parameter int NUC = 4,         // Static unicast entries
  parameter int NMC = 4          // Static multicast entries
) (
  input wire logic clk,                    // Clock, 250 MHz
  input wire logic sys_rst,                // Synchronous reset, active high
  input wire logic psel,                   // APB select
  input wire logic penable,                // APB enable
  input wire logic pwrite,                 // APB write
  input wire logic [7:0] paddr,            // APB byte address
  input wire logic [31:0] pwdata,          // APB write data
  output logic pready,                     // APB ready
  output logic [31:0] prdata,              // APB read data
  output logic pslverr,                    // APB error: unmapped or refused
  input wire logic [NPORTS-1:0] linkUpPin, // Per-port link status pins
  input wire logic monitorFull,            // Monitor port queue cannot take a copy
  input wire logic lkValid,                // Lookup request strobe
  input wire logic [4:0] lkSrcPort,        // Ingress port
  input wire mac_t lkSrcMac,               // Source address
  input wire mac_t lkDstMac,               // Destination address
  input wire vid_t lkVid,                  // Frame VLAN
  input wire logic lkDstKnown,             // Learned table knows destination
  input wire logic [4:0] lkDstPort,        // Learned destination port
  output logic resValid,                   // Result strobe
  output logic resDrop,                    // Frame discarded
  output logic [NPORTS-1:0] resFwd,        // Egress ports
  output logic resMirror,                  // Send a copy to the monitor port
  output logic [4:0] resMonitor,           // Monitor port index
  output logic resLearnOk,                 // Source address may be learned
  output fwd_kind_e resKind,               // How the egress set was found
  output logic [NPORTS-1:0] portFwdState,  // Effective spanning tree forwarding
  output logic [NPORTS-1:0] portVlanMember // Effective VLAN membership
);
  localparam word_t PMASK = word_t'((64'h1 << NPORTS) - 64'h1);

  // ****************************************
  // Register state
  // ****************************************
  logic ctrl_q;
  word_t mirTx_q, mirRx_q, vlan_q, stp_q, mirDrops_q;
  logic [4:0] monitor_q;
  word_t trunk_q [NTRUNK];
  word_t ucLo_q [NUC];
  word_t ucHi_q [NUC];
  word_t mcLo_q [NMC];
  word_t mcHi_q [NMC];
  word_t mcPorts_q [NMC];
  logic [NPORTS-1:0] linkS1_q, linkS2_q;
  word_t linkUp;
  word_t monBit;

  assign linkUp = word_t'(linkS2_q);
  assign monBit = word_t'(1) << monitor_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      linkS1_q <= '0;
      linkS2_q <= '0;
    end else begin
      linkS1_q <= linkUpPin;
      linkS2_q <= linkS1_q;
    end
  end

  // ****************************************
  // Trunk legality
  // ****************************************
  function automatic int popc(input word_t m);
    int c;
    c = 0;
    for (int i = 0; i < 32; i++) c += int'(m[i]);
    return c;
  endfunction

  function automatic logic legalTrunk(input word_t m);
    logic ok;
    int c;
    word_t one;
    ok = 1'b0;
    c = popc(m);
    one = 32'h0000_0001;
    if (WIDE) begin
      // Wide variant groupings
      // fixed port groupings
      for (int i = 0; i < 12; i++)
        if (m == ((one << i) | (one << (i + 12)))) ok = 1'b1;
      for (int i = 0; i < 12; i += 2)
        if (m == ((32'h0000_0003 << i) | (32'h0000_0003 << (i + 12)))) ok = 1'b1;
      for (int i = 0; i < 12; i += 4)
        if (m == ((32'h0000_000f << i) | (32'h0000_000f << (i + 12)))) ok = 1'b1;
      if (m == 32'h0300_0000) ok = 1'b1;
    end else begin
      for (int i = 0; i < 8; i += 2)
        if (m == (32'h0000_0003 << i)) ok = 1'b1;
      if (m == 32'h0000_000f || m == 32'h0000_00f0) ok = 1'b1;
    end
    return ok && (c == 2 || c == 4 || c == 8);
  endfunction

  // ****************************************
  // APB slave
  // ****************************************
  word_t allTrunks, otherTrunks, rdData;
  logic setup, mapped, refuse;

  assign setup = psel && !penable;

  always_comb begin
    allTrunks = '0;
    otherTrunks = '0;
    for (int t = 0; t < NTRUNK; t++) begin
      allTrunks |= trunk_q[t];
      if (paddr != `OFF_TRUNK0 + 8'(4 * t)) otherTrunks |= trunk_q[t];
    end
  end

  always_comb begin
    rdData = '0;
    mapped = 1'b1;
    refuse = 1'b0;
    case (paddr)
      `OFF_CTRL: rdData = {31'h0, ctrl_q};
      `OFF_MIR_TX, `OFF_MIR_RX: begin
        rdData = (paddr == `OFF_MIR_TX) ? mirTx_q : mirRx_q;
        refuse = |(pwdata & (allTrunks | monBit));
      end
      `OFF_MONITOR: begin
        rdData = {27'h0, monitor_q};
        refuse = |((word_t'(1) << pwdata[4:0]) & (allTrunks | mirTx_q | mirRx_q))
                 || pwdata[4:0] >= 5'(NPORTS);
      end
      `OFF_VLAN_MEMBER: rdData = vlan_q;
      `OFF_STP_FWD: rdData = stp_q;
      `OFF_MIR_DROPS: rdData = mirDrops_q;
      `OFF_LINK_UP: rdData = linkUp;
      default: begin
        mapped = 1'b0;
        for (int t = 0; t < NTRUNK; t++)
          if (paddr == `OFF_TRUNK0 + 8'(4 * t)) begin
            mapped = 1'b1;
            rdData = trunk_q[t];
            refuse = pwdata != '0 && (!legalTrunk(pwdata & PMASK) || (pwdata & ~PMASK) != '0
                     || |(pwdata & (otherTrunks | mirTx_q | mirRx_q | monBit)));
          end
        for (int e = 0; e < NUC; e++)
          for (int w = 0; w < 2; w++)
            if (paddr == `OFF_UC_BASE + 8'(e) * `UC_STRIDE + 8'(4 * w)) begin
              mapped = 1'b1;
              rdData = w == 0 ? ucLo_q[e] : ucHi_q[e];
            end
        for (int e = 0; e < NMC; e++)
          for (int w = 0; w < 3; w++)
            if (paddr == `OFF_MC_BASE + 8'(e) * `MC_STRIDE + 8'(4 * w)) begin
              mapped = 1'b1;
              rdData = w == 0 ? mcLo_q[e] : (w == 1 ? mcHi_q[e] : mcPorts_q[e]);
            end
      end
    endcase
    if (!pwrite) refuse = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= (setup && !pwrite) ? rdData : '0;
      pslverr <= setup && (!mapped || refuse);
    end
  end

  logic wrEn;
  assign wrEn = psel && penable && pready && pwrite && !pslverr;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= 1'(`RST_CTRL);
      mirTx_q <= `RST_MASK;
      mirRx_q <= `RST_MASK;
      monitor_q <= '0;
      vlan_q <= `RST_ALL_ON;
      stp_q <= `RST_ALL_ON;
      for (int t = 0; t < NTRUNK; t++) trunk_q[t] <= `RST_MASK;
      for (int e = 0; e < NUC; e++) begin
        ucLo_q[e] <= '0;
        ucHi_q[e] <= '0;
      end
      for (int e = 0; e < NMC; e++) begin
        mcLo_q[e] <= '0;
        mcHi_q[e] <= '0;
        mcPorts_q[e] <= '0;
      end
    end else if (wrEn) begin
      case (paddr)
        `OFF_CTRL: ctrl_q <= pwdata[`CTRL_MIR_EN];
        `OFF_MIR_TX: mirTx_q <= pwdata & PMASK;
        `OFF_MIR_RX: mirRx_q <= pwdata & PMASK;
        `OFF_MONITOR: monitor_q <= pwdata[4:0];
        `OFF_VLAN_MEMBER: vlan_q <= pwdata & PMASK;
        `OFF_STP_FWD: stp_q <= pwdata & PMASK;
        default: begin
          for (int t = 0; t < NTRUNK; t++)
            if (paddr == `OFF_TRUNK0 + 8'(4 * t)) trunk_q[t] <= pwdata;
          for (int e = 0; e < NUC; e++) begin
            if (paddr == `OFF_UC_BASE + 8'(e) * `UC_STRIDE) ucLo_q[e] <= pwdata;
            if (paddr == `OFF_UC_BASE + 8'(e) * `UC_STRIDE + 8'h4) ucHi_q[e] <= pwdata;
          end
          for (int e = 0; e < NMC; e++) begin
            if (paddr == `OFF_MC_BASE + 8'(e) * `MC_STRIDE) mcLo_q[e] <= pwdata;
            if (paddr == `OFF_MC_BASE + 8'(e) * `MC_STRIDE + 8'h4) mcHi_q[e] <= pwdata;
            if (paddr == `OFF_MC_BASE + 8'(e) * `MC_STRIDE + 8'h8) mcPorts_q[e] <= pwdata & PMASK;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Logical port view of trunks
  // ****************************************
  word_t stpEff, vlanEff;

  always_comb begin
    stpEff = stp_q;
    vlanEff = vlan_q;
    for (int t = 0; t < NTRUNK; t++) begin
      // Lowest member speaks for the whole trunk
      for (int p = 31; p >= 0; p--)
        if (trunk_q[t][p]) begin
          stpEff = trunk_q[t][p] && stp_q[p] ? stpEff | trunk_q[t] : stpEff & ~trunk_q[t];
          vlanEff = vlan_q[p] ? vlanEff | trunk_q[t] : vlanEff & ~trunk_q[t];
        end
    end
    stpEff &= PMASK;
    vlanEff &= PMASK;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      portFwdState <= '0;
      portVlanMember <= '0;
    end else begin
      portFwdState <= stpEff[NPORTS-1:0];
      portVlanMember <= vlanEff[NPORTS-1:0];
    end
  end

  // ****************************************
  // Frame lookup
  // ****************************************
  function automatic word_t pickMember(input word_t act, input logic [7:0] h);
    int n, k;
    word_t r;
    r = '0;
    k = 0;
    n = popc(act) == 0 ? 0 : int'(h) % popc(act);
    for (int p = 0; p < 32; p++)
      if (act[p]) begin
        if (k == n) r[p] = 1'b1;
        k++;
      end
    return r;
  endfunction

  word_t srcBit, dstSet, srcGroup, fwd;
  logic ucSrcHit, drop, copy;
  logic [7:0] hash;
  fwd_kind_e kind;

  always_comb begin
    srcBit = word_t'(1) << lkSrcPort;
    srcGroup = srcBit;
    ucSrcHit = 1'b0;
    drop = 1'b0;
    dstSet = '0;
    kind = FWD_FLOOD;
    hash = lkSrcMac[7:0] ^ lkSrcMac[15:8] ^ lkDstMac[7:0] ^ lkDstMac[15:8];
    for (int e = 0; e < NUC; e++)
      if (ucHi_q[e][`ENT_VALID] && {ucHi_q[e][15:0], ucLo_q[e]} == lkSrcMac) begin
        ucSrcHit = 1'b1;
        if (ucHi_q[e][`UC_PORT_LSB +: 5] != lkSrcPort) drop = 1'b1;
      end
    if (lkDstMac[`MAC_MCAST_BIT]) begin
      dstSet = vlanEff;
      for (int e = 0; e < NMC; e++)
        if (mcHi_q[e][`ENT_VALID] && mcHi_q[e][`MC_VID_LSB +: 12] == lkVid
            && {mcHi_q[e][15:0], mcLo_q[e]} == lkDstMac) begin
          dstSet = mcPorts_q[e];
          kind = FWD_MCAST_STATIC;
        end
    end else begin
      dstSet = lkDstKnown ? word_t'(1) << lkDstPort : vlanEff;
      kind = lkDstKnown ? FWD_UNICAST : FWD_FLOOD;
      for (int e = 0; e < NUC; e++)
        if (ucHi_q[e][`ENT_VALID] && {ucHi_q[e][15:0], ucLo_q[e]} == lkDstMac) begin
          dstSet = word_t'(1) << ucHi_q[e][`UC_PORT_LSB +: 5];
          kind = FWD_UNICAST;
        end
    end
    fwd = dstSet & stpEff & PMASK;
    for (int t = 0; t < NTRUNK; t++) begin
      if (|(trunk_q[t] & srcBit)) srcGroup |= trunk_q[t];
      if (|(fwd & trunk_q[t])) begin
        // one member per frame, load shared
        fwd = (fwd & ~trunk_q[t]) | pickMember(trunk_q[t] & linkUp & stpEff, hash);
      end
    end
    fwd &= ~srcGroup;
    if (fwd == '0 || !stpEff[lkSrcPort]) drop = 1'b1;
    if (drop) begin
      fwd = '0;
      kind = FWD_DROP;
    end
    copy = ctrl_q && (|(mirRx_q & srcBit) || |(mirTx_q & fwd));
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resValid <= 1'b0;
      resDrop <= 1'b0;
      resFwd <= '0;
      resMirror <= 1'b0;
      resMonitor <= '0;
      resLearnOk <= 1'b0;
      resKind <= FWD_DROP;
      mirDrops_q <= '0;
    end else begin
      resValid <= lkValid;
      resMonitor <= monitor_q;
      if (lkValid) begin
        resDrop <= drop;
        resFwd <= fwd[NPORTS-1:0];
        resMirror <= copy && !monitorFull;
        resLearnOk <= !ucSrcHit && !drop;
        resKind <= kind;
        if (copy && monitorFull) mirDrops_q <= mirDrops_q + 32'h1;
      end
    end
  end
endmodule // switch_fwd_ctrl

// >>> swfwd_sva.sv
// Port assertions for the forwarding control block
`timescale 1ns/10ps
`include "swfwd_regs.svh"
module swfwd_sva import swfwd_pkg::*; #(
  parameter int NPORTS = 26 // Switch ports
) (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic pready, // Ready
  input wire logic [31:0] prdata, // Read data
  input wire logic pslverr, // Error
  input wire logic lkValid, // Lookup strobe
  input wire logic [4:0] lkSrcPort, // Ingress port
  input wire logic resValid, // Result strobe
  input wire logic resDrop, // Discard
  input wire logic [NPORTS-1:0] resFwd, // Egress set
  input wire logic resMirror // Copy flag
);
  logic mirEn_q;
  logic [4:0] src_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mirEn_q <= 1'b0;
    end else if (psel && penable && pready && pwrite && !pslverr && paddr == `OFF_CTRL) begin
      mirEn_q <= pwdata[`CTRL_MIR_EN];
    end
  end
  always_ff @(posedge clk) begin
    if (lkValid) begin
      src_q <= lkSrcPort;
    end
  end
  property p_setupRdy;
    @(posedge clk) disable iff (sys_rst) psel && !penable |=> pready;
  endproperty
  a_setupRdy: assert property (p_setupRdy) else $error("no ready after setup");
  property p_rdyOne;
    @(posedge clk) disable iff (sys_rst) pready |=> !pready;
  endproperty
  a_rdyOne: assert property (p_rdyOne) else $error("ready longer than one cycle");
  property p_idleData;
    @(posedge clk) disable iff (sys_rst) !pready |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_idleData: assert property (p_idleData) else $error("read data outside access");
  property p_res;
    @(posedge clk) disable iff (sys_rst) lkValid |=> resValid;
  endproperty
  a_res: assert property (p_res) else $error("result missing");
  property p_resCause;
    @(posedge clk) disable iff (sys_rst) resValid |-> $past(lkValid);
  endproperty
  a_resCause: assert property (p_resCause) else $error("result without request");
  property p_mirOff;
    @(posedge clk) disable iff (sys_rst) resValid && !mirEn_q |-> !resMirror;
  endproperty
  a_mirOff: assert property (p_mirOff) else $error("copy while mirroring off");
  property p_srcOut;
    @(posedge clk) disable iff (sys_rst) resValid |-> !resFwd[src_q];
  endproperty
  a_srcOut: assert property (p_srcOut) else $error("frame sent back to source");
  property p_empty;
    @(posedge clk) disable iff (sys_rst) resValid && !resDrop |-> resFwd != '0;
  endproperty
  a_empty: assert property (p_empty) else $error("kept frame with no egress");
endmodule // swfwd_sva
bind switch_fwd_ctrl swfwd_sva #(.NPORTS(NPORTS)) swfwd_sva_inst (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .lkValid(lkValid),
  .lkSrcPort(lkSrcPort), .resValid(resValid), .resDrop(resDrop), .resFwd(resFwd),
  .resMirror(resMirror));

// >>> link_partner.sv
// Link partners and monitor queue seen from the switch
`timescale 1ns/10ps
module link_partner #(
  parameter int NPORTS = 26 // Switch ports
) (
  input wire logic clk, // Clock
  input wire logic cabled, // Cables connected
  input wire logic [NPORTS-1:0] cutMask, // Links pulled
  input wire logic stallMon, // Monitor stall request
  output logic [NPORTS-1:0] linkUp, // Link status
  output logic monFull // Monitor queue full
);
  always_ff @(posedge clk) begin
    linkUp <= cabled ? ~cutMask : '0;
  end
  always_ff @(posedge clk) begin
    monFull <= stallMon;
  end
endmodule // link_partner

// >>> tb.sv
// Self-checking bench for the forwarding control block
`timescale 1ns/10ps
module tb import swfwd_pkg::*;;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err, cabled, stallMon;
  logic lkValid, lkDstKnown, resValid, resDrop, resMirror, resLearnOk, monitorFull;
  logic pslverrNarrow, errNarrow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] lkSrcPort, lkDstPort, resMonitor;
  mac_t lkSrcMac, lkDstMac;
  vid_t lkVid;
  logic [25:0] linkUpPin, cutMask, resFwd, portFwdState, portVlanMember, first;
  fwd_kind_e resKind;
  int n_fail, samples_checked;
  localparam mac_t MA = 48'h0200_0000_0001;
  localparam mac_t MB = 48'h0a00_0000_0002;
  localparam mac_t MS = 48'h1122_3344_5566;
  switch_fwd_ctrl switch_fwd_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .linkUpPin(linkUpPin), .monitorFull(monitorFull),
    .lkValid(lkValid), .lkSrcPort(lkSrcPort), .lkSrcMac(lkSrcMac), .lkDstMac(lkDstMac),
    .lkVid(lkVid), .lkDstKnown(lkDstKnown), .lkDstPort(lkDstPort), .resValid(resValid),
    .resDrop(resDrop), .resFwd(resFwd), .resMirror(resMirror), .resMonitor(resMonitor),
    .resLearnOk(resLearnOk), .resKind(resKind), .portFwdState(portFwdState),
    .portVlanMember(portVlanMember));
  // Eight-port variant sees the same bus; only its refusals are judged
  switch_fwd_ctrl #(.NPORTS(8), .WIDE(1'b0)) switch_fwd_ctrl_narrow_inst (.clk(clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(), .prdata(), .pslverr(pslverrNarrow),
    .linkUpPin(linkUpPin[7:0]), .monitorFull(monitorFull), .lkValid(lkValid),
    .lkSrcPort(lkSrcPort), .lkSrcMac(lkSrcMac), .lkDstMac(lkDstMac), .lkVid(lkVid),
    .lkDstKnown(lkDstKnown), .lkDstPort(lkDstPort), .resValid(), .resDrop(), .resFwd(),
    .resMirror(), .resMonitor(), .resLearnOk(), .resKind(), .portFwdState(),
    .portVlanMember());
  link_partner link_partner_inst (.clk(clk), .cabled(cabled), .cutMask(cutMask),
    .stallMon(stallMon), .linkUp(linkUpPin), .monFull(monitorFull));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (!pready);
    rd = prdata;
    err = pslverr;
    errNarrow = pslverrNarrow;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pslverr", {31'h0, err}, {31'h0, e});
  endtask
  task automatic look(input logic [4:0] sp, input mac_t sm, input mac_t dm, input vid_t v,
    input logic [4:0] dp);
    @(posedge clk);
    lkValid <= 1'b1;
    lkSrcPort <= sp;
    lkSrcMac <= sm;
    lkDstMac <= dm;
    lkVid <= v;
    lkDstKnown <= (dp != 5'h1f);
    lkDstPort <= dp;
    @(posedge clk);
    lkValid <= 1'b0;
    do @(posedge clk); while (!resValid);
  endtask
  task automatic t_trunk;
    apb(1'b0, 8'h3c, 32'h0, 1'b1);
    chk("unmapped", rd, 32'h0);
    apb(1'b1, 8'h0c, 32'h5, 1'b0);
    apb(1'b1, 8'h18, 32'h0002_0020, 1'b1);
    apb(1'b1, 8'h10, 32'h7, 1'b1);
    apb(1'b1, 8'h18, 32'hf00f, 1'b0);
    apb(1'b1, 8'h18, 32'h0, 1'b0);
    apb(1'b1, 8'h10, 32'h3, 1'b1);
    apb(1'b1, 8'h10, 32'h1001, 1'b0);
    apb(1'b1, 8'h14, 32'h1001, 1'b1);
    apb(1'b1, 8'h14, 32'h0300_0000, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 1'b0);
    chk("trunk0", rd, 32'h1001);
  endtask
  task automatic t_narrow;
    apb(1'b1, 8'h1c, 32'hc, 1'b1);
    chk("narrow", {31'h0, errNarrow}, 32'h0);
    apb(1'b1, 8'h1c, 32'h6, 1'b1);
    chk("narrow", {31'h0, errNarrow}, 32'h1);
    apb(1'b1, 8'h1c, 32'hc0, 1'b1);
    chk("narrow", {31'h0, errNarrow}, 32'h0);
    apb(1'b1, 8'h1c, 32'h0, 1'b0);
    chk("narrow", {31'h0, errNarrow}, 32'h0);
  endtask
  task automatic t_mirror;
    apb(1'b1, 8'h04, 32'h1, 1'b1);
    apb(1'b1, 8'h0c, 32'h0, 1'b1);
    apb(1'b1, 8'h0c, 32'h5, 1'b0);
    apb(1'b1, 8'h08, 32'h20, 1'b1);
    apb(1'b1, 8'h08, 32'h8, 1'b0);
    look(5'd3, MA, MB, 12'd1, 5'h1f);
    chk("mirror", {31'h0, resMirror}, 32'h0);
    apb(1'b1, 8'h00, 32'h1, 1'b0);
    look(5'd3, MA, MB, 12'd1, 5'h1f);
    chk("mirror", {31'h0, resMirror}, 32'h1);
    chk("monitor", {27'h0, resMonitor}, 32'h5);
    stallMon <= 1'b1;
    look(5'd3, MA, MB, 12'd1, 5'h1f);
    chk("mirror", {31'h0, resMirror}, 32'h0);
    stallMon <= 1'b0;
    apb(1'b0, 8'h28, 32'h0, 1'b0);
    chk("drops", rd, 32'h1);
  endtask
  task automatic t_static;
    apb(1'b1, 8'h40, 32'h3344_5566, 1'b0);
    apb(1'b1, 8'h44, 32'h8004_1122, 1'b0);
    look(5'd6, MS, MB, 12'd1, 5'd7);
    chk("drop", {31'h0, resDrop}, 32'h1);
    chk("learn", {31'h0, resLearnOk}, 32'h0);
    look(5'd4, MS, MB, 12'd1, 5'd7);
    chk("drop", {31'h0, resDrop}, 32'h0);
    chk("egress", {6'h0, resFwd}, 32'h80);
    apb(1'b1, 8'h80, 32'h5e00_0001, 1'b0);
    apb(1'b1, 8'h84, 32'h8005_0100, 1'b0);
    apb(1'b1, 8'h88, 32'h300, 1'b0);
    look(5'd7, MA, 48'h0100_5e00_0001, 12'd5, 5'h1f);
    chk("kind", resKind, FWD_MCAST_STATIC);
    chk("egress", {6'h0, resFwd}, 32'h300);
    look(5'd7, MA, 48'h0100_5e00_0001, 12'd6, 5'h1f);
    chk("kind", resKind, FWD_FLOOD);
  endtask
  task automatic t_share;
    look(5'd7, MA, MB, 12'd1, 5'd0);
    first = resFwd;
    chk("member", {6'h0, first}, 32'h1000);
    chk("members", $countones(first & 26'h1001), 32'h1);
    look(5'd7, MA, MB, 12'd1, 5'd0);
    chk("flow", {6'h0, resFwd}, {6'h0, first});
    cutMask <= 26'h1000;
    repeat (5) @(posedge clk);
    look(5'd7, MA, MB, 12'd1, 5'd0);
    chk("failover", {6'h0, resFwd}, 32'h1);
    cutMask <= '0;
    apb(1'b1, 8'h24, 32'hffff_fffe, 1'b0);
    apb(1'b1, 8'h20, 32'hffff_fffe, 1'b0);
    repeat (2) @(posedge clk);
    chk("stp", {31'h0, portFwdState[12]}, 32'h0);
    chk("vlan", {31'h0, portVlanMember[12]}, 32'h0);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end
  initial begin
    {psel, penable, pwrite, lkValid, lkDstKnown, stallMon, cabled} = '0;
    {paddr, pwdata, lkSrcPort, lkDstPort, lkSrcMac, lkDstMac, lkVid, cutMask} = '0;
    n_fail = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    cabled <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 1'b0);
    chk("ctrl", rd, 32'h0);
    t_trunk();
    t_narrow();
    t_mirror();
    t_static();
    t_share();
    results();
  end
endmodule // tb
